//--- rtl/bsfs_supervisor.sv
// Soft-start sequencer and fault supervisor for a single-phase buck controller.
//
// Function
// - POR clear and enable start soft-start ramp.
// - Soft-start end sets done, releases power-good, enables emulation.
// - Overcurrent qualified over 10 us latches off.
// - Overcurrent pulls power-good with strongest strength.
// - Overcurrent/undervoltage latch cleared by enable low or POR.
// - Overvoltage qualified above 116 percent over 2 us.
// - Overvoltage pulls power-good middle strength, latches off.
// - Overvoltage latch cleared only by POR.
// - Overvoltage low-side drive hysteretic on/off, 2 us.
// - Undervoltage qualified below 84 percent over 2 us.
// - Undervoltage pulls power-good weakest strength, latches off.
// - Over-temperature suspends modulation, forces both drives low unless overvoltage is latched.
// - Over-temperature leaves power-good and latches unchanged.
// - Modulation resumes once over-temperature indication clears.
// - Enable low or POR also clears over-temperature.
// - Fault detectors stay active during over-temperature.
// - Continuous conduction kept until soft-start done.
// - Power-good undefined before POR; held released here.
// - Soft-start pulls power-good with weakest strength.
`timescale 1ns/1ns
`default_nettype none
`include "bsfs_defines.svh"
module bsfs_supervisor #(
    parameter int CNT_W = `BSFS_CNT_W
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic por_ok_in,
    input wire logic enable_in,
    input wire logic softstart_end_in,
    input wire logic oc_above_in,
    input wire logic fb_above_ov_rise_in,
    input wire logic fb_below_ov_fall_in,
    input wire logic fb_below_uv_in,
    input wire logic overtemp_in,
    input wire logic pwm_high_in,
    input wire logic pwm_low_in,
    output logic softstart_clamp_release_out,
    output logic setpoint_amp_enable_out,
    output logic softstart_done_flag_out,
    output logic diode_emulation_mode_out,
    output logic continuous_conduction_mode_out,
    output logic pwm_suspend_out,
    output logic high_side_drive_out,
    output logic low_side_drive_out,
    output logic power_good_pd_oe_out,
    output logic [1:0] power_good_strength_out,
    output logic overcurrent_fault_out,
    output logic overvoltage_fault_out,
    output logic undervoltage_fault_out,
    output logic overtemp_state_out
);
    // ------------------------------------------------------------------
    // Reset release and input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Every input is an analog comparator or pin level, so all pass two stages.
    localparam int NIN = 10;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1_q;
    logic [NIN-1:0] sync2_q;

    assign raw_in = {por_ok_in, enable_in, softstart_end_in, oc_above_in,
                     fb_above_ov_rise_in, fb_below_ov_fall_in, fb_below_uv_in,
                     overtemp_in, pwm_high_in, pwm_low_in};

    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= raw_in;
            sync2_q <= sync1_q;
        end
    end

    logic por_ok;
    logic en;
    logic ss_end;
    logic oc_cond;
    logic ov_rise;
    logic ov_fall;
    logic uv_cond;
    logic ot_cond;
    logic pwm_hi;
    logic pwm_lo;

    assign por_ok = sync2_q[9];
    assign en = sync2_q[8];
    assign ss_end = sync2_q[7];
    assign oc_cond = sync2_q[6];
    assign ov_rise = sync2_q[5];
    assign ov_fall = sync2_q[4];
    assign uv_cond = sync2_q[3];
    assign ot_cond = sync2_q[2];
    assign pwm_hi = sync2_q[1];
    assign pwm_lo = sync2_q[0];

    // ------------------------------------------------------------------
    // Debounce timers
    // ------------------------------------------------------------------
    logic oc_qual;
    logic ov_qual;
    logic ovf_qual;
    logic uv_qual;
    logic active;

    // Detectors run whenever the controller is enabled, over-temperature included.
    assign active = por_ok && en;

    bsfs_debounce #(
        .CNT_W(CNT_W),
        .LIMIT(CNT_W'(`BSFS_OC_CYCLES))
    ) u_db_oc (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .cond_in(oc_cond && active),
        .qual_out(oc_qual)
    );

    bsfs_debounce #(
        .CNT_W(CNT_W),
        .LIMIT(CNT_W'(`BSFS_OV_CYCLES))
    ) u_db_ov (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .cond_in(ov_rise && por_ok),
        .qual_out(ov_qual)
    );

    bsfs_debounce #(
        .CNT_W(CNT_W),
        .LIMIT(CNT_W'(`BSFS_OV_CYCLES))
    ) u_db_ovf (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .cond_in(ov_fall && por_ok),
        .qual_out(ovf_qual)
    );

    bsfs_debounce #(
        .CNT_W(CNT_W),
        .LIMIT(CNT_W'(`BSFS_UV_CYCLES))
    ) u_db_uv (
        .clk_in(clk_sys_in),
        .rst_n_in(rst_n),
        .cond_in(uv_cond && active),
        .qual_out(uv_qual)
    );

    // ------------------------------------------------------------------
    // Supervisor state
    // ------------------------------------------------------------------
    typedef struct packed {
        bsfs_pkg::bsfs_seq_t seq;
        bsfs_pkg::bsfs_first_t first;
        logic oc;
        logic ov;
        logic uv;
        logic ot;
        logic ls_dis;
        logic clamp_rel;
        logic amp_en;
        logic ss_done;
        logic diode_emulation_mode;
        logic continuous_conduction_mode;
        logic suspend;
        logic hs;
        logic ls;
        logic pg_oe;
        bsfs_pkg::bsfs_pg_t pg;
    } bsfs_state_t;

    bsfs_state_t st_q;
    bsfs_state_t st_d;

    // ------------------------------------------------------------------
    // Latch-off helper
    // ------------------------------------------------------------------
    // One place decides what counts as latched off, for the hold and the forcing alike.
    function automatic logic bsfs_any_latch(input bsfs_state_t s);
        bsfs_any_latch = s.oc || s.ov || s.uv;
    endfunction

    logic latched_off;
    assign latched_off = bsfs_any_latch(st_q);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        // Overvoltage latch ignores enable and is cleared only by POR.
        if (!por_ok) begin
            st_d = '0;
            st_d.continuous_conduction_mode = 1'b1;
        end else begin
            if (!en) begin
                st_d.oc = 1'b0;
                st_d.uv = 1'b0;
                st_d.ot = 1'b0;
                st_d.seq = bsfs_pkg::BSFS_ST_OFF;
                // An overvoltage latch outlives enable, so its code stays on the pin.
                if (st_q.ov) begin
                    st_d.first = bsfs_pkg::BSFS_FF_OV;
                end else begin
                    st_d.first = bsfs_pkg::BSFS_FF_NONE;
                end
            end else begin
                st_d.ot = ot_cond;
                if (oc_qual) begin
                    st_d.oc = 1'b1;
                end
                if (uv_qual) begin
                    st_d.uv = 1'b1;
                end
            end
            if (ov_qual) begin
                st_d.ov = 1'b1;
            end
            // The first latch to set owns the power-good code.
            if (st_q.first == bsfs_pkg::BSFS_FF_NONE) begin
                if (oc_qual && en) begin
                    st_d.first = bsfs_pkg::BSFS_FF_OC;
                end else if (ov_qual) begin
                    st_d.first = bsfs_pkg::BSFS_FF_OV;
                end else if (uv_qual && en) begin
                    st_d.first = bsfs_pkg::BSFS_FF_UV;
                end
            end
            case (st_q.seq)
                bsfs_pkg::BSFS_ST_OFF: begin
                    st_d.ss_done = 1'b0;
                    if (en && !latched_off) begin
                        st_d.seq = bsfs_pkg::BSFS_ST_SOFTSTART;
                    end
                end
                bsfs_pkg::BSFS_ST_SOFTSTART: begin
                    if (en && ss_end) begin
                        st_d.seq = bsfs_pkg::BSFS_ST_RUN;
                        st_d.ss_done = 1'b1;
                    end
                end
                bsfs_pkg::BSFS_ST_RUN: begin
                    st_d.ss_done = en;
                end
                default: begin
                    st_d.seq = bsfs_pkg::BSFS_ST_OFF;
                end
            endcase
            // A latched-off converter leaves emulation at once and restarts only from OFF.
            if (bsfs_any_latch(st_d)) begin
                st_d.seq = bsfs_pkg::BSFS_ST_OFF;
                st_d.ss_done = 1'b0;
            end
            st_d.clamp_rel = (st_d.seq != bsfs_pkg::BSFS_ST_OFF);
            st_d.amp_en = st_d.clamp_rel;
            st_d.diode_emulation_mode = st_d.ss_done;
            st_d.continuous_conduction_mode = !st_d.ss_done;
            // Latched off for overvoltage, the low side follows the hysteresis band.
            if (st_d.ov) begin
                if (ov_qual) begin
                    st_d.ls_dis = 1'b1;
                end else if (ovf_qual) begin
                    st_d.ls_dis = 1'b0;
                end
            end else begin
                st_d.ls_dis = 1'b0;
            end
            st_d.suspend = st_d.ot || (st_d.seq == bsfs_pkg::BSFS_ST_OFF);
            if (st_d.ov) begin
                st_d.hs = 1'b0;
                st_d.ls = st_d.ls_dis;
            end else if (st_d.suspend) begin
                st_d.hs = 1'b0;
                st_d.ls = 1'b0;
            end else begin
                st_d.hs = pwm_hi;
                st_d.ls = pwm_lo && !pwm_hi;
            end
            // Power-good ignores the over-temperature flag entirely.
            case (st_d.first)
                bsfs_pkg::BSFS_FF_OC: st_d.pg = bsfs_pkg::BSFS_PG_STRONG;
                bsfs_pkg::BSFS_FF_OV: st_d.pg = bsfs_pkg::BSFS_PG_MID;
                bsfs_pkg::BSFS_FF_UV: st_d.pg = bsfs_pkg::BSFS_PG_WEAK;
                default: begin
                    if (st_d.ss_done) begin
                        st_d.pg = bsfs_pkg::BSFS_PG_HIZ;
                    end else begin
                        st_d.pg = bsfs_pkg::BSFS_PG_WEAK;
                    end
                end
            endcase
            st_d.pg_oe = (st_d.pg != bsfs_pkg::BSFS_PG_HIZ);
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Before POR the pin is defined as released; any value would be legal.
    always_ff @(posedge clk_sys_in or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign softstart_clamp_release_out = st_q.clamp_rel;
    assign setpoint_amp_enable_out = st_q.amp_en;
    assign softstart_done_flag_out = st_q.ss_done;
    assign diode_emulation_mode_out = st_q.diode_emulation_mode;
    assign continuous_conduction_mode_out = st_q.continuous_conduction_mode;
    assign pwm_suspend_out = st_q.suspend;
    assign high_side_drive_out = st_q.hs;
    assign low_side_drive_out = st_q.ls;
    assign power_good_pd_oe_out = st_q.pg_oe;
    assign power_good_strength_out = st_q.pg;
    assign overcurrent_fault_out = st_q.oc;
    assign overvoltage_fault_out = st_q.ov;
    assign undervoltage_fault_out = st_q.uv;
    assign overtemp_state_out = st_q.ot;
endmodule
`default_nettype wire

//--- rtl/bsfs_defines.svh
// Timing and encoding constants for the buck soft-start fault supervisor.
`ifndef BSFS_DEFINES_SVH
`define BSFS_DEFINES_SVH

`define BSFS_CLK_HZ 20000000
`define BSFS_OC_TIME_NS 10000
`define BSFS_OV_TIME_NS 2000
`define BSFS_UV_TIME_NS 2000
`define BSFS_OC_CYCLES ((`BSFS_OC_TIME_NS * (`BSFS_CLK_HZ / 1000000)) / 1000)
`define BSFS_OV_CYCLES ((`BSFS_OV_TIME_NS * (`BSFS_CLK_HZ / 1000000)) / 1000)
`define BSFS_UV_CYCLES ((`BSFS_UV_TIME_NS * (`BSFS_CLK_HZ / 1000000)) / 1000)
`define BSFS_CNT_W 9

`endif

//--- rtl/bsfs_pkg.sv
// Types shared by the buck soft-start fault supervisor.
package bsfs_pkg;

    typedef enum logic [1:0] {
        BSFS_PG_HIZ,
        BSFS_PG_WEAK,
        BSFS_PG_MID,
        BSFS_PG_STRONG
    } bsfs_pg_t;

    typedef enum logic [1:0] {
        BSFS_ST_OFF,
        BSFS_ST_SOFTSTART,
        BSFS_ST_RUN
    } bsfs_seq_t;

    typedef enum logic [1:0] {
        BSFS_FF_NONE,
        BSFS_FF_OC,
        BSFS_FF_OV,
        BSFS_FF_UV
    } bsfs_first_t;

endpackage

//--- rtl/bsfs_debounce.sv
// Qualification timer: output rises once the condition has held longer than a count.
`timescale 1ns/1ns
`default_nettype none
module bsfs_debounce #(
    parameter int CNT_W = 9,
    parameter logic [CNT_W-1:0] LIMIT = 9'h028
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic cond_in,
    output logic qual_out
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic qual;
    } bsfs_db_state_t;

    bsfs_db_state_t st_q;
    bsfs_db_state_t st_d;

    // The count must reach the limit and the condition hold one cycle more, so it holds strictly longer than the time.
    always_comb begin
        st_d = st_q;
        if (!cond_in) begin
            st_d.cnt = '0;
            st_d.qual = 1'b0;
        end else if (st_q.cnt < LIMIT) begin
            st_d.cnt = st_q.cnt + 1'b1;
        end else begin
            st_d.qual = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign qual_out = st_q.qual;
endmodule
`default_nettype wire

//--- bench/bsfs_analog_model.sv
// Comparator model for the supervisor's analog sense inputs.
`timescale 1ns/1ns
`default_nettype none
module bsfs_analog_model (
    input wire logic [7:0] fb_pct_in,
    input wire logic oc_load_in,
    output logic oc_above_out,
    output logic ov_rise_out,
    output logic ov_fall_out,
    output logic uv_out
);
    // Feedback is given in percent of the setpoint; comparators are ideal.
    assign oc_above_out = oc_load_in;
    assign ov_rise_out = fb_pct_in > 8'h74;
    assign ov_fall_out = fb_pct_in < 8'h66;
    assign uv_out = fb_pct_in < 8'h54;
endmodule
`default_nettype wire

//--- bench/bsfs_supervisor_checker.sv
// Port assertions for the buck soft-start fault supervisor.
`timescale 1ns/1ns
`default_nettype none
module bsfs_supervisor_checker (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic por_ok_in,
    input wire logic enable_in,
    input wire logic oc_above_in,
    input wire logic fb_above_ov_rise_in,
    input wire logic fb_below_uv_in,
    input wire logic softstart_clamp_release_out,
    input wire logic setpoint_amp_enable_out,
    input wire logic softstart_done_flag_out,
    input wire logic diode_emulation_mode_out,
    input wire logic continuous_conduction_mode_out,
    input wire logic high_side_drive_out,
    input wire logic low_side_drive_out,
    input wire logic power_good_pd_oe_out,
    input wire logic [1:0] power_good_strength_out,
    input wire logic overcurrent_fault_out,
    input wire logic overvoltage_fault_out,
    input wire logic undervoltage_fault_out,
    input wire logic overtemp_state_out
);
    logic [7:0] oc_run_q, ov_run_q, uv_run_q;
    // ----------------------------------------
    // Run counters
    // ----------------------------------------
    // They saturate, since only a lower bound on the run is ever asserted.
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            oc_run_q <= 8'h00;
            ov_run_q <= 8'h00;
            uv_run_q <= 8'h00;
        end else begin
            oc_run_q <= oc_above_in ? oc_run_q + {7'h00, oc_run_q != 8'hFF} : 8'h00;
            ov_run_q <= fb_above_ov_rise_in ? ov_run_q + {7'h00, ov_run_q != 8'hFF} : 8'h00;
            uv_run_q <= fb_below_uv_in ? uv_run_q + {7'h00, uv_run_q != 8'hFF} : 8'h00;
        end
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_por_held;
        por_ok_in [*4];
    endsequence
    sequence s_on_held;
        (por_ok_in && enable_in) [*4];
    endsequence
    AST_START: assert property (
        $rose(softstart_clamp_release_out) |-> setpoint_amp_enable_out && $past(enable_in, 2))
        else $error("start without enable");
    AST_DEM_DONE: assert property (
        diode_emulation_mode_out == softstart_done_flag_out) else $error("emulation mismatch");
    AST_CCM: assert property (
        softstart_clamp_release_out |-> softstart_done_flag_out != continuous_conduction_mode_out)
        else $error("conduction mode mismatch");
    AST_OC_RUN: assert property (
        $rose(overcurrent_fault_out) |-> oc_run_q >= 8'hCA) else $error("overcurrent too early");
    AST_OV_RUN: assert property (
        $rose(overvoltage_fault_out) |-> ov_run_q >= 8'h2A) else $error("overvoltage too early");
    AST_UV_RUN: assert property (
        $rose(undervoltage_fault_out) |-> uv_run_q >= 8'h2A) else $error("undervoltage too early");
    AST_OC_CODE: assert property (
        $rose(overcurrent_fault_out) && !overvoltage_fault_out && !undervoltage_fault_out
        |-> ##[0:1] power_good_pd_oe_out && power_good_strength_out == 2'h3)
        else $error("overcurrent code wrong");
    AST_OV_HOLD: assert property (
        s_por_held ##0 overvoltage_fault_out |=> overvoltage_fault_out)
        else $error("overvoltage latch lost");
    AST_OC_HOLD: assert property (
        s_on_held ##0 overcurrent_fault_out |=> overcurrent_fault_out)
        else $error("overcurrent latch lost");
    AST_OT_GATE: assert property (
        overtemp_state_out && $past(overtemp_state_out) |-> !high_side_drive_out)
        else $error("high side on in overtemp");
    AST_OT_LOW: assert property (
        overtemp_state_out && $past(overtemp_state_out) && !overvoltage_fault_out
        |-> !low_side_drive_out) else $error("low side on in overtemp");
endmodule
bind bsfs_supervisor bsfs_supervisor_checker u_bsfs_supervisor_checker (.*);
`default_nettype wire

//--- bench/bsfs_supervisor_bench.sv
// Self-checking bench for the buck soft-start fault supervisor.
`timescale 1ns/1ns
`default_nettype none
module bsfs_supervisor_bench;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic por_ok_in = 1'b0;
    logic enable_in = 1'b0;
    logic softstart_end_in = 1'b0;
    logic overtemp_in = 1'b0;
    logic pwm_high_in = 1'b1;
    logic pwm_low_in = 1'b0;
    logic oc_load = 1'b0;
    logic [7:0] fb_pct = 8'h64;
    logic oc_above_in, fb_above_ov_rise_in, fb_below_ov_fall_in, fb_below_uv_in;
    logic softstart_clamp_release_out, setpoint_amp_enable_out, softstart_done_flag_out;
    logic diode_emulation_mode_out, continuous_conduction_mode_out, pwm_suspend_out;
    logic high_side_drive_out, low_side_drive_out, power_good_pd_oe_out;
    logic [1:0] power_good_strength_out;
    logic overcurrent_fault_out, overvoltage_fault_out, undervoltage_fault_out;
    logic overtemp_state_out;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    always #25 clk_sys_in = ~clk_sys_in;
    bsfs_supervisor u_bsfs_supervisor (.*);
    bsfs_analog_model u_bsfs_analog_model (.fb_pct_in(fb_pct), .oc_load_in(oc_load),
        .oc_above_out(oc_above_in), .ov_rise_out(fb_above_ov_rise_in),
        .ov_fall_out(fb_below_ov_fall_in), .uv_out(fb_below_uv_in));
    task give_verdict;
        if (err_total == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 8000) begin
            err_total++;
            give_verdict();
        end
    end
    task chk(input string nm, input logic [1:0] exp, input logic [1:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    // Inputs change only by non-blocking assignment at a rising edge.
    task set(input logic p, e, s, t, o, input logic [7:0] f);
        @(posedge clk_sys_in);
        por_ok_in <= p;
        enable_in <= e;
        softstart_end_in <= s;
        overtemp_in <= t;
        oc_load <= o;
        fb_pct <= f;
    endtask
    task wt(input int n);
        repeat (n) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
    endtask
    task start;
        set(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h64);
        wt(6);
        chk("clamp", 2'h1, softstart_clamp_release_out);
        chk("amp", 2'h1, setpoint_amp_enable_out);
        chk("pg_ss", 2'h1, power_good_strength_out);
        chk("ccm_ss", 2'h1, continuous_conduction_mode_out);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h64);
        wt(6);
        chk("done", 2'h1, softstart_done_flag_out);
        chk("dem", 2'h1, diode_emulation_mode_out);
        chk("pg_run", 2'h0, power_good_pd_oe_out);
        chk("hs_run", 2'h1, high_side_drive_out);
    endtask
    initial begin
        repeat (12) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        start();
        // Overvoltage: a broken run must restart the qualification count.
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h78);
        wt(30);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h64);
        wt(5);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h78);
        wt(30);
        chk("ov_early", 2'h0, overvoltage_fault_out);
        wt(30);
        chk("ov", 2'h1, overvoltage_fault_out);
        chk("pg_ov", 2'h2, power_good_strength_out);
        chk("ls_on", 2'h1, low_side_drive_out);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h65);
        wt(60);
        chk("ls_off", 2'h0, low_side_drive_out);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h78);
        wt(60);
        chk("ls_again", 2'h1, low_side_drive_out);
        set(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h64);
        wt(10);
        chk("ov_en_low", 2'h1, overvoltage_fault_out);
        set(1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h64);
        wt(230);
        chk("pg_first", 2'h2, power_good_strength_out);
        chk("no_restart", 2'h0, softstart_clamp_release_out);
        set(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h64);
        wt(6);
        chk("ov_por", 2'h0, overvoltage_fault_out);
        // Overcurrent, with an undervoltage arriving second.
        start();
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h64);
        wt(150);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h64);
        wt(5);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h64);
        wt(150);
        chk("oc_early", 2'h0, overcurrent_fault_out);
        wt(70);
        chk("oc", 2'h1, overcurrent_fault_out);
        chk("pg_oc", 2'h3, power_good_strength_out);
        chk("hs_oc", 2'h0, high_side_drive_out);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h50);
        wt(60);
        chk("pg_oc_first", 2'h3, power_good_strength_out);
        set(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h64);
        wt(6);
        chk("oc_clear", 2'h0, overcurrent_fault_out);
        // Undervoltage, cleared by the supply reset.
        start();
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h50);
        wt(60);
        chk("uv", 2'h1, undervoltage_fault_out);
        chk("pg_uv", 2'h1, power_good_strength_out);
        chk("pg_uv_oe", 2'h1, power_good_pd_oe_out);
        set(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 8'h64);
        wt(6);
        chk("uv_por", 2'h0, undervoltage_fault_out);
        // Over-temperature: suspend, resume, clear by enable, faults still live.
        start();
        set(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h64);
        wt(6);
        chk("ot", 2'h1, overtemp_state_out);
        chk("ot_susp", 2'h1, pwm_suspend_out);
        chk("ot_hs", 2'h0, high_side_drive_out);
        chk("ot_pg", 2'h0, power_good_pd_oe_out);
        set(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h64);
        wt(6);
        chk("ot_off", 2'h0, overtemp_state_out);
        chk("ot_resume", 2'h1, high_side_drive_out);
        @(posedge clk_sys_in);
        pwm_high_in <= 1'b0;
        pwm_low_in <= 1'b1;
        wt(6);
        chk("ls_run", 2'h1, low_side_drive_out);
        set(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 8'h50);
        wt(6);
        chk("ot_ls", 2'h0, low_side_drive_out);
        wt(54);
        chk("ot_uv", 2'h1, undervoltage_fault_out);
        set(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h64);
        wt(6);
        chk("ot_en", 2'h0, overtemp_state_out);
        give_verdict();
    end
endmodule
`default_nettype wire
